// ===== rtl/ipv_ctrl.sv
// Interrupt priority and vector-address unit: request collection, level table,
// grant hand-off to the core and a small event/interrupt register set.
// Assumes one 50 MHz clock; core, debug and peripheral requests are levels on that
// clock, the two external request pins and the variant strap are asynchronous.
//
// Contract
// R1: Level 3 before 2 before 1 before 0.
// R2: Same level: smallest vector number wins.
// R3: Entry address is relative to vector base.
// R4: Two words per entry; table reach is 19 bits (the code carries 21-bit base and entry addresses).
// R5: Vectors 0 and 1 never issued as interrupts.
// R6: Software puts jumps at 0,1, calls elsewhere.
// R7: Core exceptions level 3; soft interrupts fixed 2,1,0.
// R8: Debug events 6,7,9,10,11 at levels 1-3.
// R9: External pins and peripherals take levels 0-2.
// R10: Low voltage at 20, PLL at 21.
// R11: Flash events at vectors 22, 23, 24.
// R12: CAN events at vectors 26 to 29.
// R13: IO ports F..A at vectors 30..35.
// R14: SPI1 at 38,39; SPI0 at 40,41.
// R15: Serial 1 at 42,43,45,46; 44 unused.
// R16: Decoder 1 at 47,48; decoder 0 at 49,50.
// R17: Reserved and absent sources never request or win.
// R18: Vector and address held together until acknowledged.
`timescale 1ns/10ps
`default_nettype none
module ipv_ctrl
  import ipv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [RAW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  output logic irq,
  input wire logic small_variant,
  input wire logic [3:0] core_exc_req,
  input wire logic [2:0] sw_int_req,
  input wire logic [4:0] debug_req,
  input wire logic ext_request_a,
  input wire logic ext_request_b,
  input wire logic low_voltage_detect_req,
  input wire logic pll_req,
  input wire logic [2:0] flash_module_req,
  input wire logic [3:0] can_req,
  input wire logic [5:0] io_port_req,
  input wire logic [3:0] spi_req,
  input wire logic [3:0] serial_comm_1_req,
  input wire logic [3:0] quad_decoder_req,
  output logic grant_valid,
  output logic [VW-1:0] grant_vec,
  output logic [AW-1:0] grant_addr,
  input wire logic core_ack
);

  // Reset release through two flops
  logic [1:0] rst_ff_r;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_ff_r <= 2'h0;
    end else begin
      rst_ff_r <= {rst_ff_r[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_ff_r[1];

  // Pin synchronisers and strap capture
  logic [1:0] ext_meta_r;
  logic [1:0] ext_sync_r;
  logic strap_meta_r;
  logic strap_sync_r;
  logic variant_r;
  logic variant_done_r;
  logic [1:0] strap_age_r;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ext_meta_r <= 2'h0;
      ext_sync_r <= 2'h0;
      strap_meta_r <= 1'b0;
      strap_sync_r <= 1'b0;
    end else begin
      ext_meta_r <= {ext_request_b, ext_request_a};
      ext_sync_r <= ext_meta_r;
      strap_meta_r <= small_variant;
      strap_sync_r <= strap_meta_r;
    end
  end

  // The strap is taken debug_unit, after it has crossed; later changes are ignored.
  // The synchroniser leaves reset together with this logic, so taking the
  // strap at debug_unit would capture the flops' reset value instead of the pin.
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      variant_r <= 1'b0;
      variant_done_r <= 1'b0;
      strap_age_r <= 2'h0;
    end else if (!variant_done_r) begin
      strap_age_r <= strap_age_r + 2'h1;
      if (strap_age_r == STRAP_SETTLE_CYC) begin
        variant_r <= strap_sync_r;
        variant_done_r <= 1'b1;
      end
    end
  end

  a_strap_debug_unit: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // see R17
    variant_done_r |=> $stable(variant_r))
    else $error("variant strap changed after capture");

  // Request map onto vector numbers
  logic [NVEC-1:0] req_raw_w;
  logic [NVEC-1:0] allow_w;
  logic [NVEC-1:0] pend_w;

  assign req_raw_w = {
    13'h0000,
    quad_decoder_req,                          // see R16
    serial_comm_1_req[3:2], 1'b0,              // see R15
    serial_comm_1_req[1:0],                    // see R15
    spi_req,                                   // see R14
    2'h0,
    io_port_req[0], io_port_req[1], io_port_req[2],
    io_port_req[3], io_port_req[4], io_port_req[5], // see R13
    can_req,                                   // see R12
    1'b0,
    flash_module_req,                          // see R11
    pll_req, low_voltage_detect_req,           // see R10
    1'b0,
    ext_sync_r[1], ext_sync_r[0],              // see R9
    sw_int_req[0], sw_int_req[1], sw_int_req[2], // see R7
    2'h0,
    debug_req[4:2], 1'b0, debug_req[1:0],      // see R8
    core_exc_req,                              // see R7
    2'h0                                       // see R5
  };

  assign allow_w = VALID_MASK & ~(variant_r ? SMALL_ABSENT : '0); // see R17
  assign pend_w = req_raw_w & allow_w; // see R5 see R17

  // Register file
  logic [AW-1:0] vector_base_r;
  logic [NVEC*LW-1:0] lvl_r;
  logic ctrl_en_r;
  logic [IW-1:0] int_stat_r;
  logic [IW-1:0] int_mask_r;
  logic [DW-1:0] reg_rdata_r;
  logic irq_r;
  logic [3:0] lvl_wr_w;
  logic [IW-1:0] stat_set_w;
  logic [IW-1:0] stat_clr_w;
  logic [DW-1:0] gstat_w;
  logic [DW-1:0] rd_mux_w;

  assign lvl_wr_w[0] = reg_wr && reg_addr == A_LVL0;
  assign lvl_wr_w[1] = reg_wr && reg_addr == A_LVL1;
  assign lvl_wr_w[2] = reg_wr && reg_addr == A_LVL2;
  assign lvl_wr_w[3] = reg_wr && reg_addr == A_LVL3;
  assign stat_clr_w = (reg_wr && reg_addr == A_ISTAT) ? reg_wdata[IW-1:0] : '0;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      vector_base_r <= VBASE_RST;
      ctrl_en_r <= CTRL_EN_RST;
      int_mask_r <= IMASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == A_VBASE) begin
        vector_base_r <= reg_wdata[AW-1:0]; // see R3
      end
      if (reg_addr == A_CTRL) begin
        ctrl_en_r <= reg_wdata[CTRL_EN_BIT];
      end
      if (reg_addr == A_IMASK) begin
        int_mask_r <= reg_wdata[IW-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lvl_r <= LVL_RST;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (lvl_wr_w[k]) begin
          lvl_r[DW*k +: DW] <= reg_wdata;
        end
      end
    end
  end

  // Fixed and clamped levels per vector
  logic [NVEC*LW-1:0] lvl_eff_w;

  always_comb begin
    lvl_eff_w = '0;
    for (int v = 0; v < NVEC; v++) begin
      lvl_eff_w[LW*v +: LW] = vec_level(v[VW-1:0], lvl_r[LW*v +: LW]); // see R7 see R8 see R9
    end
  end

  // Arbitration
  logic win_valid_w;
  logic [VW-1:0] win_vec_w;
  logic [LW-1:0] win_lvl_w;

  ipv_arb u_arb (
    .clk(sys_clk),
    .rst_n(rst_sync_n),
    .pend(pend_w),
    .lvl(lvl_eff_w),
    .win_valid_r(win_valid_w),
    .win_vec_r(win_vec_w),
    .win_lvl_r(win_lvl_w)
  );

  // Grant hand-off to the core
  logic grant_valid_r;
  logic [VW-1:0] grant_vec_r;
  logic [AW-1:0] grant_addr_r;
  logic [LW-1:0] grant_lvl_r;
  logic [1:0] holdoff_r;
  logic take_w;
  logic ack_evt_w;
  logic spur_evt_w;

  // The pick is one cycle old, so the winner must still be pending when taken
  assign take_w = ctrl_en_r && !grant_valid_r && holdoff_r == 2'h0 &&
                  win_valid_w && pend_w[win_vec_w];
  assign ack_evt_w = grant_valid_r && core_ack;
  assign spur_evt_w = core_ack && !grant_valid_r;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      grant_valid_r <= 1'b0;
      grant_vec_r <= '0;
      grant_addr_r <= '0;
      grant_lvl_r <= '0;
      holdoff_r <= 2'h0;
    end else if (take_w) begin
      grant_valid_r <= 1'b1;
      grant_vec_r <= win_vec_w; // see R18
      grant_addr_r <= entry_addr(vector_base_r, win_vec_w); // see R3 see R4 see R18
      grant_lvl_r <= win_lvl_w;
    end else if (ack_evt_w) begin
      grant_valid_r <= 1'b0;
      holdoff_r <= HOLDOFF_CYC;
    end else if (holdoff_r != 2'h0) begin
      holdoff_r <= holdoff_r - 2'h1;
    end
  end

  // Event flags: a new event beats a clear in the same cycle
  assign stat_set_w = {spur_evt_w, ack_evt_w};

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      int_stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      int_stat_r <= (int_stat_r & ~stat_clr_w) | stat_set_w;
      irq_r <= |(int_stat_r & int_mask_r);
    end
  end

  // Read path
  assign gstat_w = {15'h0000, variant_r, 5'h00, grant_lvl_r, grant_valid_r, 2'h0, grant_vec_r};
  assign rd_mux_w =
    (reg_addr == A_VBASE)   ? {{(DW-AW){1'b0}}, vector_base_r} :
    (reg_addr == A_LVL0)    ? lvl_r[DW*0 +: DW] :
    (reg_addr == A_LVL1)    ? lvl_r[DW*1 +: DW] :
    (reg_addr == A_LVL2)    ? lvl_r[DW*2 +: DW] :
    (reg_addr == A_LVL3)    ? lvl_r[DW*3 +: DW] :
    (reg_addr == A_CTRL)    ? {{(DW-1){1'b0}}, ctrl_en_r} :
    (reg_addr == A_GSTAT)   ? gstat_w :
    (reg_addr == A_ISTAT)   ? {{(DW-IW){1'b0}}, int_stat_r} :
    (reg_addr == A_IMASK)   ? {{(DW-IW){1'b0}}, int_mask_r} :
    (reg_addr == A_PEND_LO) ? pend_w[DW-1:0] :
    (reg_addr == A_PEND_HI) ? pend_w[NVEC-1:DW] :
    '0;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata_r <= '0;
    end else begin
      reg_rdata_r <= reg_rd ? rd_mux_w : '0;
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign irq = irq_r;
  assign grant_valid = grant_valid_r;
  assign grant_vec = grant_vec_r;
  assign grant_addr = grant_addr_r;

  // Checks
  logic [NVEC-1:0] pend_q;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_w;
    end
  end

  a_grant_hold: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // see R18
    grant_valid_r && !core_ack |=> grant_valid_r && $stable(grant_vec_r) &&
    $stable(grant_addr_r))
    else $error("grant changed before the core acknowledged it");

  a_entry_addr: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // see R3
    $rose(grant_valid_r) |->
    grant_addr_r == $past(vector_base_r) + {{(AW-VW-1){1'b0}}, grant_vec_r, 1'b0})
    else $error("entry address does not match base plus twice the vector");

  a_no_reset_vec: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // see R5
    grant_valid_r |-> grant_vec_r >= V_CORE_LO)
    else $error("reset overlay vector issued as interrupt");

  a_no_reserved: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // see R17
    grant_valid_r |-> VALID_MASK[grant_vec_r] &&
    !(variant_r && SMALL_ABSENT[grant_vec_r]))
    else $error("reserved or absent vector granted");

  a_core_level: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // see R7
    grant_valid_r |->
    (grant_vec_r inside {[V_CORE_LO:V_CORE_HI]} ? grant_lvl_r == 2'h3 : 1'b1) &&
    (grant_vec_r == V_SW2 ? grant_lvl_r == 2'h2 : 1'b1) &&
    (grant_vec_r == V_SW1 ? grant_lvl_r == 2'h1 : 1'b1) &&
    (grant_vec_r == V_SW0 ? grant_lvl_r == 2'h0 : 1'b1))
    else $error("core source granted at the wrong level");

  a_dbg_level: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // see R8
    grant_valid_r && DBG_MASK[grant_vec_r] |-> grant_lvl_r != 2'h0)
    else $error("debug event granted at level 0");

  a_periph_level: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // see R9
    grant_valid_r && grant_vec_r >= V_EXT_A |-> grant_lvl_r <= 2'h2)
    else $error("external or peripheral source above level 2");

  a_source_map: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // see R10
    $rose(grant_valid_r) |-> pend_q[grant_vec_r])
    else $error("granted vector had no pending source");

  a_ack_event: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) // see R18
    grant_valid_r && core_ack |=> !grant_valid_r && int_stat_r[IS_ACK_BIT] ##1
    !grant_valid_r)
    else $error("acknowledge did not retire the grant and flag it");

endmodule
`default_nettype wire

// ===== rtl/ipv_pkg.sv
// Constants, register map and vector decoding for the interrupt priority unit.
// Assumes a single system clock; all addresses are byte offsets on the plain register port.
package ipv_pkg;

  localparam int NVEC = 64;
  localparam int VW = 6;
  localparam int AW = 21;
  localparam int LW = 2;
  localparam int DW = 32;
  localparam int RAW = 6;

  // Register offsets
  localparam logic [RAW-1:0] A_VBASE = 6'h00;
  localparam logic [RAW-1:0] A_LVL0 = 6'h04;
  localparam logic [RAW-1:0] A_LVL1 = 6'h08;
  localparam logic [RAW-1:0] A_LVL2 = 6'h0C;
  localparam logic [RAW-1:0] A_LVL3 = 6'h10;
  localparam logic [RAW-1:0] A_CTRL = 6'h14;
  localparam logic [RAW-1:0] A_GSTAT = 6'h18;
  localparam logic [RAW-1:0] A_ISTAT = 6'h1C;
  localparam logic [RAW-1:0] A_IMASK = 6'h20;
  localparam logic [RAW-1:0] A_PEND_LO = 6'h24;
  localparam logic [RAW-1:0] A_PEND_HI = 6'h28;

  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int GS_VEC_LSB = 0;
  localparam int GS_VALID_BIT = 8;
  localparam int GS_LVL_LSB = 9;
  localparam int GS_VARIANT_BIT = 16;
  localparam int IS_ACK_BIT = 0;
  localparam int IS_SPUR_BIT = 1;
  localparam int IW = 2;

  // Reset values
  localparam logic [AW-1:0] VBASE_RST = 21'h00_0000;
  localparam logic [NVEC*LW-1:0] LVL_RST = 128'h0;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic [IW-1:0] IMASK_RST = 2'h0;

  // Cycles a just-acknowledged source gets to drop its request
  localparam logic [1:0] HOLDOFF_CYC = 2'h2;

  // Cycles after internal reset release before the crossed strap is trusted
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;

  // Vector classes
  localparam logic [NVEC-1:0] VALID_MASK = 64'h0007_EFCF_FDF7_CEFC;
  localparam logic [NVEC-1:0] SMALL_ABSENT = 64'h0001_8000_3C00_0000;
  localparam logic [NVEC-1:0] DBG_MASK = 64'h0000_0000_0000_0EC0;
  localparam logic [VW-1:0] V_CORE_LO = 6'h02;
  localparam logic [VW-1:0] V_CORE_HI = 6'h05;
  localparam logic [VW-1:0] V_SW2 = 6'h0E;
  localparam logic [VW-1:0] V_SW1 = 6'h0F;
  localparam logic [VW-1:0] V_SW0 = 6'h10;
  localparam logic [VW-1:0] V_EXT_A = 6'h11;
  localparam logic [LW-1:0] LVL_TOP = 2'h3;
  localparam logic [LW-1:0] LVL_PERIPH_MAX = 2'h2;
  localparam logic [LW-1:0] LVL_DBG_MIN = 2'h1;

  // Effective level: fixed sources ignore the programmed field, others are clamped
  function automatic logic [LW-1:0] vec_level(input logic [VW-1:0] vec,
                                              input logic [LW-1:0] raw);
    logic [LW-1:0] res;
    res = raw;
    if (vec >= V_CORE_LO && vec <= V_CORE_HI) begin
      res = LVL_TOP;
    end else if (vec == V_SW2) begin
      res = 2'h2;
    end else if (vec == V_SW1) begin
      res = 2'h1;
    end else if (vec == V_SW0) begin
      res = 2'h0;
    end else if (DBG_MASK[vec]) begin
      res = (raw < LVL_DBG_MIN) ? LVL_DBG_MIN : raw;
    end else if (raw > LVL_PERIPH_MAX) begin
      res = LVL_PERIPH_MAX;
    end
    return res;
  endfunction

  // Two program words per entry, placed relative to the table base
  function automatic logic [AW-1:0] entry_addr(input logic [AW-1:0] base,
                                               input logic [VW-1:0] vec);
    return base + {{(AW-VW-1){1'b0}}, vec, 1'b0};
  endfunction

endpackage

// ===== rtl/ipv_arb.sv
// Priority pick over all pending vectors: highest level first, then lowest vector.
// Assumes pend and lvl come from logic on the same clock; result is registered.
`timescale 1ns/10ps
`default_nettype none
module ipv_arb
  import ipv_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NVEC-1:0] pend,
  input wire logic [NVEC*LW-1:0] lvl,
  output logic win_valid_r,
  output logic [VW-1:0] win_vec_r,
  output logic [LW-1:0] win_lvl_r
);

  logic found_w;
  logic [VW-1:0] best_v_w;
  logic [LW-1:0] best_l_w;

  // Walking downward with >= lets the lower vector take a tie
  always_comb begin
    found_w = 1'b0;
    best_v_w = '0;
    best_l_w = '0;
    for (int v = NVEC - 1; v >= 0; v--) begin
      if (pend[v] && (!found_w || lvl[LW*v +: LW] >= best_l_w)) begin // see R1 see R2
        found_w = 1'b1;
        best_v_w = v[VW-1:0];
        best_l_w = lvl[LW*v +: LW];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_valid_r <= 1'b0;
      win_vec_r <= '0;
      win_lvl_r <= '0;
    end else begin
      win_valid_r <= found_w;
      win_vec_r <= best_v_w;
      win_lvl_r <= best_l_w;
    end
  end

  // Helper copies for checking the pick against last cycle's inputs
  logic [NVEC-1:0] pend_q;
  logic [NVEC*LW-1:0] lvl_q;
  logic higher_q_w;
  logic tie_lower_w;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
      lvl_q <= '0;
    end else begin
      pend_q <= pend;
      lvl_q <= lvl;
    end
  end

  always_comb begin
    higher_q_w = 1'b0;
    tie_lower_w = 1'b0;
    for (int v = 0; v < NVEC; v++) begin
      if (pend_q[v] && lvl_q[LW*v +: LW] > win_lvl_r) begin
        higher_q_w = 1'b1;
      end
      if (pend_q[v] && lvl_q[LW*v +: LW] == win_lvl_r && v < int'(win_vec_r)) begin
        tie_lower_w = 1'b1;
      end
    end
  end

  a_level_first: assert property (@(posedge clk) disable iff (!rst_n) // see R1
    win_valid_r |-> !higher_q_w && pend_q[win_vec_r])
    else $error("winner is not at the highest pending level");

  a_lowest_vector: assert property (@(posedge clk) disable iff (!rst_n) // see R2
    win_valid_r |-> !tie_lower_w)
    else $error("a lower vector at the same level was passed over");

endmodule
`default_nettype wire

// ===== test/ipv_core_model.sv
// Core-side model: takes each grant after a set delay and answers with one ack pulse.
// Assumes the grant outputs are registered on sys_clk and held until acknowledged.
`timescale 1ns/10ps
`default_nettype none
module ipv_core_model
  import ipv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic grant_valid,
  input wire logic [VW-1:0] grant_vec,
  input wire logic [AW-1:0] grant_addr,
  input wire logic [3:0] ack_dly,
  input wire logic stray_ack,
  output logic core_ack,
  output logic [VW-1:0] seen_vec,
  output logic [AW-1:0] seen_addr,
  output logic entry_is_call
);
  logic [3:0] wait_r;
  logic busy_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_ack <= 1'b0;
      wait_r <= 4'h0;
      busy_r <= 1'b0;
      seen_vec <= '0;
      seen_addr <= '0;
      entry_is_call <= 1'b0;
    end else begin
      core_ack <= 1'b0;
      if (grant_valid && !busy_r) begin
        wait_r <= wait_r + 4'h1;
        if (wait_r >= ack_dly) begin
          core_ack <= 1'b1;
          busy_r <= 1'b1;
          seen_vec <= grant_vec;
          seen_addr <= grant_addr;
          // Entries 0 and 1 hold jumps, so only a call entry may be fetched here
          entry_is_call <= (grant_vec > 6'h01);
        end
      end else if (!grant_valid) begin
        // Stray ack only when commanded, to provoke the no-grant event
        core_ack <= stray_ack;
        busy_r <= 1'b0;
        wait_r <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/interrupt_priority_vector_unit_tb_top.sv
// Self-checking bench for the interrupt priority unit with a core model.
// Assumes the unit's register map and grant timing as handed over.
`timescale 1ns/10ps
`default_nettype none
module interrupt_priority_vector_unit_tb_top;
  import ipv_pkg::*;
  localparam logic [63:0] OK = 64'h0007_EFCF_FDF7_CEFC;
  localparam logic [63:0] ABS = 64'h0001_8000_3C00_0000;
  localparam logic [63:0] DBG = 64'h0000_0000_0000_0EC0;
  logic sys_clk, rst_n, reg_wr, reg_rd, small_variant, irq, grant_valid, core_ack;
  logic stray_ack, entry_is_call;
  logic [RAW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata;
  logic [VW-1:0] grant_vec, seen_vec;
  logic [AW-1:0] grant_addr, seen_addr, base;
  logic [63:0] src;
  logic [127:0] prog;
  logic [3:0] ack_dly;
  int seed = 32'h3bbdf60b;
  int miscompares = 0;
  int checked = 0;

  ipv_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .small_variant(small_variant), .core_exc_req(src[5:2]),
    .sw_int_req({src[14], src[15], src[16]}),
    .debug_req({src[11], src[10], src[9], src[7], src[6]}),
    .ext_request_a(src[17]), .ext_request_b(src[18]),
    .low_voltage_detect_req(src[20]), .pll_req(src[21]),
    .flash_module_req(src[24:22]), .can_req(src[29:26]),
    .io_port_req({src[30], src[31], src[32], src[33], src[34], src[35]}),
    .spi_req(src[41:38]), .serial_comm_1_req({src[46], src[45], src[43], src[42]}),
    .quad_decoder_req(src[50:47]), .grant_valid(grant_valid), .grant_vec(grant_vec),
    .grant_addr(grant_addr), .core_ack(core_ack));

  ipv_core_model core (.sys_clk(sys_clk), .rst_n(rst_n), .grant_valid(grant_valid),
    .grant_vec(grant_vec), .grant_addr(grant_addr), .ack_dly(ack_dly),
    .stray_ack(stray_ack), .core_ack(core_ack), .seen_vec(seen_vec),
    .seen_addr(seen_addr), .entry_is_call(entry_is_call));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [RAW-1:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [RAW-1:0] a, input logic [DW-1:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, e);
  endtask

  function automatic logic [1:0] eff(input int v, input logic [1:0] r);
    if (v >= 2 && v <= 5) return 2'h3;
    if (v >= 14 && v <= 16) return 2'(16 - v);
    if (DBG[v]) return (r == 2'h0) ? 2'h1 : r;
    return (r == 2'h3) ? 2'h2 : r;
  endfunction

  // Highest level wins; scanning upward keeps the smaller vector on a tie
  function automatic int win(input logic [63:0] s);
    int b;
    b = -1;
    for (int v = 0; v < 64; v++) begin
      if (s[v] && (b < 0 || eff(v, prog[2*v+:2]) > eff(b, prog[2*b+:2]))) begin
        b = v;
      end
    end
    return b;
  endfunction

  task automatic serve(input int v);
    int n;
    n = 0;
    while (grant_valid !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    chk(grant_valid, 1'b1);
    chk(grant_vec, v);
    chk(grant_addr, 21'(base + 21'(2 * v)));
    // Source drops before the ack so the holdoff is never relied upon
    @(posedge sys_clk);
    src[v] <= 1'b0;
    ack_dly <= 4'(2 + ({$random(seed)} % 5));
    n = 0;
    while (core_ack !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    chk(seen_vec, v);
    chk(seen_addr, 21'(base + 21'(2 * v)));
    chk(entry_is_call, 1'b1);
    chk(grant_valid, 1'b0);
  endtask

  task automatic run_set(input logic [63:0] s);
    wr(A_CTRL, 32'h0);
    @(posedge sys_clk);
    src <= s;
    repeat (6) @(negedge sys_clk);
    chk(grant_valid, 1'b0);
    rd_chk(A_PEND_LO, s[31:0]);
    rd_chk(A_PEND_HI, s[63:32]);
    wr(A_CTRL, 32'h1);
    while (src != 64'h0) serve(win(src));
  endtask

  task automatic load_levels();
    for (int w = 0; w < 4; w++) wr(A_LVL0 + 6'(4 * w), prog[32*w+:32]);
  endtask

  initial begin
    repeat (90000) @(posedge sys_clk);
    miscompares++;
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    small_variant = 1'b0;
    stray_ack = 1'b0;
    ack_dly = 4'h2;
    src = '0;
    prog = '0;
    base = '0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd_chk(A_VBASE, 32'h0);
    rd_chk(A_CTRL, 32'h0);
    rd_chk(A_IMASK, 32'h0);
    rd_chk(6'h3C, 32'h0);
    base = 21'h1A_2C46;
    wr(A_VBASE, 32'(base));
    rd_chk(A_VBASE, 32'(base));
    for (int v = 0; v < 64; v++) if (OK[v]) run_set(64'h1 << v);
    rd_chk(A_ISTAT, 32'h1);
    wr(A_IMASK, 32'h3);
    repeat (2) @(negedge sys_clk);
    chk(irq, 1'b1);
    wr(A_ISTAT, 32'h1);
    repeat (2) @(negedge sys_clk);
    chk(irq, 1'b0);
    @(posedge sys_clk);
    stray_ack <= 1'b1;
    @(posedge sys_clk);
    stray_ack <= 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(irq, 1'b1);
    rd_chk(A_ISTAT, 32'h2);
    wr(A_IMASK, 32'h1);
    repeat (2) @(negedge sys_clk);
    chk(irq, 1'b0);
    wr(A_ISTAT, 32'h2);
    rd_chk(A_ISTAT, 32'h0);
    for (int r = 0; r < 28; r++) begin
      prog = {$random(seed), $random(seed), $random(seed), $random(seed)};
      if (r == 0) prog = {128{1'b1}};
      if (r == 1) prog = '0;
      base = 21'($random(seed));
      wr(A_VBASE, 32'(base));
      load_levels();
      rd_chk(A_LVL3, prog[127:96]);
      run_set({$random(seed), $random(seed)} & OK);
    end
    // Second reset brings up the smaller variant
    @(posedge sys_clk);
    rst_n <= 1'b0;
    small_variant <= 1'b1;
    src <= '0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    prog = '0;
    base = '0;
    repeat (8) @(posedge sys_clk);
    rd_chk(A_GSTAT, 32'h0001_0000);
    wr(A_CTRL, 32'h1);
    @(posedge sys_clk);
    src <= ABS;
    repeat (15) @(negedge sys_clk);
    chk(grant_valid, 1'b0);
    rd_chk(A_PEND_LO, 32'h0);
    rd_chk(A_PEND_HI, 32'h0);
    run_set({$random(seed), $random(seed)} & OK & ~ABS);
    test_done();
  end
endmodule
`default_nettype wire
